// File: hw/iao_top.sv
// Interlocked auxiliary output with Wishbone configuration registers
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module iao_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Vehicle pins
    input  wire logic        switch_i,
    input  wire logic        park_brake_i,
    input  wire logic        door_open_i,
    input  wire logic        power_takeoff_i,
    input  wire logic        engine_running_i,
    input  wire logic        auto_trans_i,
    // Measured values from on-chip logic, same clock
    input  wire logic [7:0]  speed_mph_i,
    input  wire logic [7:0]  gear_i,
    input  wire logic [7:0]  load_current_i,
    // Load drive and status
    output logic             load_on_o,
    output logic             fuse_fault_o
);
    //==============================================================
    // Pin synchronisation
    logic [iao_pkg::PIN_W-1:0] pins_raw;
    logic [iao_pkg::PIN_W-1:0] pins_q;
    assign pins_raw = {auto_trans_i, engine_running_i, power_takeoff_i,
                       door_open_i, park_brake_i, switch_i};

    iao_sync #(
        .W (iao_pkg::PIN_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (pins_raw),
        .level_o (pins_q)
    );

    wire sw_q     = pins_q[0];
    wire brake_q  = pins_q[1];
    wire door_q   = pins_q[2];
    wire pto_q    = pins_q[3];
    wire engine_q = pins_q[4];
    wire auto_q   = pins_q[5];

    //==============================================================
    // Configuration registers
    logic [4:0] code_reg;
    logic       latch_reg;
    logic [6:0] speed_thr_reg;
    logic [7:0] gear_thr_reg;
    logic [7:0] fuse_reg;
    logic       ack_reg;
    logic [31:0] rdata_reg;

    wire        req      = wb_cyc_i && wb_stb_i && !ack_reg;
    wire        wr       = req && wb_we_i;
    wire        hit_ctrl  = (wb_adr_i == {1'b0, iao_pkg::ADDR_CTRL});
    wire        hit_speed = (wb_adr_i == {1'b0, iao_pkg::ADDR_SPEED});
    wire        hit_gear  = (wb_adr_i == {1'b0, iao_pkg::ADDR_GEAR});
    wire        hit_fuse  = (wb_adr_i == {1'b0, iao_pkg::ADDR_FUSE});
    wire        hit_stat  = (wb_adr_i == iao_pkg::ADDR_STATUS);
    wire        wr_b0    = wr && wb_sel_i[0];
    wire        wr_b1    = wr && wb_sel_i[1];

    // Out-of-range speed and fuse settings saturate; codes above CODE_MAX are stored as written and hold the output off
    wire [7:0]  wd8        = wb_dat_i[7:0];
    wire [6:0]  speed_next = (wd8 > {1'b0, iao_pkg::SPEED_MAX}) ?
                             iao_pkg::SPEED_MAX : wd8[6:0];
    wire [7:0]  fuse_next  = (wd8 < iao_pkg::FUSE_MIN) ? iao_pkg::FUSE_MIN :
                             (wd8 > iao_pkg::FUSE_MAX) ? iao_pkg::FUSE_MAX :
                             wd8;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_reg      <= iao_pkg::CODE_RESET;
            latch_reg     <= 1'b0;
            speed_thr_reg <= iao_pkg::SPEED_RESET;
            gear_thr_reg  <= iao_pkg::GEAR_RESET;
            fuse_reg      <= iao_pkg::FUSE_RESET;
        end else begin
            if (wr_b0 && hit_ctrl) begin
                code_reg <= wb_dat_i[4:0];
            end
            if (wr_b1 && hit_ctrl) begin
                latch_reg <= wb_dat_i[iao_pkg::CTRL_LATCH_BIT];
            end
            if (wr_b0 && hit_speed) begin
                speed_thr_reg <= speed_next;
            end
            if (wr_b0 && hit_gear) begin
                gear_thr_reg <= wd8;
            end
            if (wr_b0 && hit_fuse) begin
                fuse_reg <= fuse_next;
            end
        end
    end

    //==============================================================
    // Interlock condition decode
    logic [16:0] cond_vec;
    wire [7:0]  speed_thr8 = {1'b0, speed_thr_reg};
    // Threshold compares only reach the output through codes 9, 10, 13, 14
    assign cond_vec[0]  = 1'b1;
    assign cond_vec[1]  = brake_q;
    assign cond_vec[2]  = !brake_q;
    assign cond_vec[3]  = door_q;
    assign cond_vec[4]  = !door_q;
    assign cond_vec[5]  = pto_q;
    assign cond_vec[6]  = !pto_q;
    assign cond_vec[7]  = engine_q;
    assign cond_vec[8]  = !engine_q;
    assign cond_vec[9]  = speed_mph_i > speed_thr8;
    assign cond_vec[10] = speed_mph_i < speed_thr8;
    assign cond_vec[11] = speed_mph_i == 8'h0_000;
    assign cond_vec[12] = speed_mph_i != 8'h0_000;
    // Gear tests need an automatic transmission to mean anything
    assign cond_vec[13] = auto_q && (gear_i > gear_thr_reg);
    assign cond_vec[14] = auto_q && (gear_i < gear_thr_reg);
    assign cond_vec[15] = auto_q && (gear_i == iao_pkg::GEAR_NEUTRAL);
    assign cond_vec[16] = auto_q && (gear_i != iao_pkg::GEAR_NEUTRAL);

    wire code_ok = (code_reg <= iao_pkg::CODE_MAX);
    wire cond_ok = code_ok && cond_vec[code_reg];
    wire over    = load_current_i >= fuse_reg;

    //==============================================================
    // Output state machine
    iao_pkg::iao_state_e state_reg;
    iao_pkg::iao_state_e state_next;
    logic       sw_prev_reg;
    logic       fault_reg;
    wire        sw_rise = sw_q && !sw_prev_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            iao_pkg::ST_OFF: begin
                if (sw_q && cond_ok) begin
                    state_next = iao_pkg::ST_ON;
                end
            end
            iao_pkg::ST_ON: begin
                if (!sw_q) begin
                    state_next = iao_pkg::ST_OFF;
                end else if (over) begin
                    state_next = iao_pkg::ST_FUSED;
                end else if (!cond_ok) begin
                    state_next = latch_reg ? iao_pkg::ST_LATCHED
                                           : iao_pkg::ST_OFF;
                end
            end
            iao_pkg::ST_LATCHED,
            iao_pkg::ST_FUSED: begin
                // Only letting go of the switch rearms the output
                if (!sw_q) begin
                    state_next = iao_pkg::ST_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= iao_pkg::ST_OFF;
            sw_prev_reg <= 1'b0;
            fault_reg   <= 1'b0;
        end else begin
            state_reg   <= state_next;
            sw_prev_reg <= sw_q;
            // A trip in the same cycle as a rearm keeps the flag
            if (state_reg == iao_pkg::ST_ON && sw_q && over) begin
                fault_reg <= 1'b1;
            end else if (sw_rise) begin
                fault_reg <= 1'b0;
            end
        end
    end

    assign load_on_o    = (state_reg == iao_pkg::ST_ON);
    assign fuse_fault_o = fault_reg;

    //==============================================================
    // Bus answer: one wait state, unmapped reads return zero
    logic [31:0] rsel;
    assign rsel = hit_ctrl  ? {23'h0, latch_reg, 3'h0, code_reg} :
                  hit_speed ? {25'h0, speed_thr_reg} :
                  hit_gear  ? {24'h0, gear_thr_reg} :
                  hit_fuse  ? {24'h0, fuse_reg} :
                  hit_stat  ? {27'h0, sw_q, fault_reg,
                               state_reg == iao_pkg::ST_LATCHED,
                               cond_ok, load_on_o} :
                  32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            if (req && !wb_we_i) begin
                rdata_reg <= rsel;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    //==============================================================
    // Assertions
    property p_bus_ack;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("bus request not answered in one cycle");

    property p_on_cause;
        @(posedge clk_i) disable iff (rst_i)
        $rose(load_on_o) |-> $past(sw_q) && $past(cond_ok);
    endproperty
    a_on_cause: assert property (p_on_cause)
        else $error("output rose without switch and condition");

    property p_plain;
        @(posedge clk_i) disable iff (rst_i)
        (code_reg == 5'h0_000 && sw_q && !over &&
         state_reg == iao_pkg::ST_OFF) |=> load_on_o;
    endproperty
    a_plain: assert property (p_plain)
        else $error("code zero did not follow the switch");

    property p_bad_code;
        @(posedge clk_i) disable iff (rst_i)
        (code_reg > iao_pkg::CODE_MAX) |=> !load_on_o;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("illegal code left output on");

    property p_brake;
        @(posedge clk_i) disable iff (rst_i)
        (code_reg == 5'h0_001 && load_on_o && !brake_q && !latch_reg)
        |=> !load_on_o ##1 (!load_on_o || $past(cond_ok));
    endproperty
    a_brake: assert property (p_brake)
        else $error("park brake interlock did not drop output");

    property p_speed;
        @(posedge clk_i) disable iff (rst_i)
        (code_reg == 5'h0_009 && sw_q && state_reg == iao_pkg::ST_OFF &&
         speed_mph_i > {1'b0, speed_thr_reg}) |=> load_on_o;
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed above threshold did not enable output");

    property p_relatch;
        @(posedge clk_i) disable iff (rst_i)
        (state_reg == iao_pkg::ST_LATCHED && sw_q)
        |=> !load_on_o;
    endproperty
    a_relatch: assert property (p_relatch)
        else $error("latched output came back without switch cycle");

    property p_fuse;
        @(posedge clk_i) disable iff (rst_i)
        (load_on_o && sw_q && over) |=> !load_on_o && fuse_fault_o;
    endproperty
    a_fuse: assert property (p_fuse)
        else $error("overcurrent did not trip the fuse");

    property p_speed_range;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |-> speed_thr_reg <= iao_pkg::SPEED_MAX;
    endproperty
    a_speed_range: assert property (p_speed_range)
        else $error("speed threshold above limit");

    property p_neutral;
        @(posedge clk_i) disable iff (rst_i)
        // A code rewrite while on only takes effect one cycle later
        (code_reg == 5'h0_00F && $past(code_reg) == 5'h0_00F && load_on_o)
        |-> $past(auto_q) && $past(gear_i) == iao_pkg::GEAR_NEUTRAL;
    endproperty
    a_neutral: assert property (p_neutral)
        else $error("neutral interlock on outside neutral");

    c_fuse_trip: cover property (@(posedge clk_i) disable iff (rst_i)
        load_on_o ##1 fuse_fault_o);
    c_latched: cover property (@(posedge clk_i) disable iff (rst_i)
        state_reg == iao_pkg::ST_LATCHED ##1 !sw_q);
    c_speed_on: cover property (@(posedge clk_i) disable iff (rst_i)
        code_reg == 5'h0_009 && load_on_o);
endmodule : iao_top

// File: hw/iao_pkg.sv
// Constants and state types for the interlocked auxiliary output
//==================================================================
//==================================================================
package iao_pkg;
    // Register byte offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_SPEED  = 4'h4;
    localparam logic [3:0] ADDR_GEAR   = 4'h8;
    localparam logic [3:0] ADDR_FUSE   = 4'hC;
    localparam logic [4:0] ADDR_STATUS = 5'h10;

    // Field positions
    localparam int CTRL_LATCH_BIT = 8;
    localparam int ST_OUT_BIT     = 0;
    localparam int ST_OK_BIT      = 1;
    localparam int ST_LATCHED_BIT = 2;
    localparam int ST_FAULT_BIT   = 3;
    localparam int ST_SWITCH_BIT  = 4;

    // Reset values and limits
    localparam logic [4:0] CODE_RESET    = 5'h0_00A;
    localparam logic [4:0] CODE_MAX      = 5'h0_010;
    localparam logic [6:0] SPEED_RESET   = 7'h0_01E;
    localparam logic [6:0] SPEED_MAX     = 7'h0_064;
    localparam logic [7:0] GEAR_RESET    = 8'h0_000;
    localparam logic [7:0] GEAR_NEUTRAL  = 8'h0_07D;
    // Fuse level in tenths of an ampere
    localparam logic [7:0] FUSE_RESET    = 8'h0_0C8;
    localparam logic [7:0] FUSE_MIN      = 8'h0_00A;
    localparam logic [7:0] FUSE_MAX      = 8'h0_0C8;

    // Number of synchronised status pins
    localparam int PIN_W = 6;

    typedef enum logic [1:0] {
        ST_OFF     = 2'b00,
        ST_ON      = 2'b01,
        ST_LATCHED = 2'b10,
        ST_FUSED   = 2'b11
    } iao_state_e;
endpackage : iao_pkg

// File: hw/iao_sync.sv
// Three-stage pin synchroniser with agreement filter per bit
`timescale 1ns/10ps
module iao_sync #(
    parameter int W = 6
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    //==============================================================
    // Per-bit chain
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            // Stage one feeds stage two only, to keep metastability out
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg <= pin_i[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign level_o[i] = lvl_reg;
        end
    endgenerate
endmodule : iao_sync

// File: sim/iao_vehicle.sv
// Vehicle-side model: switch, status pins, measured values and load
`timescale 1ns/10ps
module iao_vehicle (
    input  wire logic       clk_i,
    input  wire logic       load_on_i,
    input  wire logic [5:0] pins_cmd_i,
    input  wire logic [7:0] speed_cmd_i,
    input  wire logic [7:0] gear_cmd_i,
    input  wire logic [7:0] amps_cmd_i,
    output logic      [5:0] pins_o         = 6'h00,
    output logic      [7:0] speed_mph_o    = 8'h00,
    output logic      [7:0] gear_o         = 8'h00,
    output logic      [7:0] load_current_o = 8'h00
);
    //==========================================================
    // Pins follow the commanded vehicle state one edge later
    always @(posedge clk_i) begin
        pins_o      <= pins_cmd_i;
        speed_mph_o <= speed_cmd_i;
        gear_o      <= gear_cmd_i;
        // A real load draws current only while it is driven
        load_current_o <= load_on_i ? amps_cmd_i : 8'h00;
    end
endmodule : iao_vehicle

// File: sim/iao_top_bench.sv
// Self-checking bench for the interlocked auxiliary output
`timescale 1ns/10ps
module iao_top_bench;
    typedef struct packed {
        logic        chk;
        logic [31:0] mask;
        logic [31:0] val;
    } iao_exp_s;
    localparam logic [4:0] A_CTRL  = {1'b0, iao_pkg::ADDR_CTRL};
    localparam logic [4:0] A_SPEED = {1'b0, iao_pkg::ADDR_SPEED};
    localparam logic [4:0] A_GEAR  = {1'b0, iao_pkg::ADDR_GEAR};
    localparam logic [4:0] A_FUSE  = {1'b0, iao_pkg::ADDR_FUSE};
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [4:0]  wb_adr_i = 5'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        load_on_o;
    logic        fuse_fault_o;
    logic [5:0]  pins_cmd  = 6'h00;
    logic [7:0]  speed_cmd = 8'h00;
    logic [7:0]  gear_cmd  = 8'h00;
    logic [7:0]  amps_cmd  = 8'h00;
    logic [5:0]  pins;
    logic [7:0]  speed, gear, amps;
    logic [7:0]  spd_thr, gear_thr, s, g;
    logic [5:0]  p;
    iao_exp_s    exp_q[$];
    iao_exp_s    mon_e;
    int          err_count       = 0;
    int          samples_checked = 0;
    int          seed            = 62;

    always #5 clk_i = ~clk_i;

    iao_vehicle i_vehicle (.clk_i(clk_i), .load_on_i(load_on_o),
        .pins_cmd_i(pins_cmd), .speed_cmd_i(speed_cmd),
        .gear_cmd_i(gear_cmd), .amps_cmd_i(amps_cmd), .pins_o(pins),
        .speed_mph_o(speed), .gear_o(gear), .load_current_o(amps));

    iao_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .switch_i(pins[0]), .park_brake_i(pins[1]),
        .door_open_i(pins[2]), .power_takeoff_i(pins[3]),
        .engine_running_i(pins[4]), .auto_trans_i(pins[5]),
        .speed_mph_i(speed), .gear_i(gear), .load_current_i(amps),
        .load_on_o(load_on_o), .fuse_fault_o(fuse_fault_o));

    //==========================================================
    // Checking
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // Oldest note is matched against each acknowledged transfer
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            if (mon_e.chk) begin
                check("read", wb_dat_o & mon_e.mask, mon_e.val);
                // Pins are compared on status reads only
                if (mon_e.mask == 32'h0000_0009) begin
                    check("load", {31'h0, load_on_o}, {31'h0, mon_e.val[0]});
                    check("fault", {31'h0, fuse_fault_o}, {31'h0, mon_e.val[3]});
                end
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        end_of_test();
    end

    //==========================================================
    // Bus and vehicle drivers
    task automatic wb(input logic we, input logic [4:0] adr,
                      input logic [31:0] dat, input logic [31:0] mask,
                      input logic [31:0] want);
        exp_q.push_back('{!we, mask, want});
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        // No latency is assumed; only the watchdog ends a lost answer
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat, 32'h0000_0000, 32'h0000_0000);
    endtask : wr

    task automatic rd(input logic [4:0] adr, input logic [31:0] mask,
                      input logic [31:0] want);
        wb(1'b0, adr, 32'h0000_0000, mask, want);
    endtask : rd

    // Output and fault bits of the status word, pins compared too
    task automatic status(input logic on, input logic fault);
        rd(iao_pkg::ADDR_STATUS, 32'h0000_0009, {28'h0, fault, 2'b00, on});
    endtask : status

    // Eight edges cover pin synchronisation plus the state update
    task automatic drive(input logic [5:0] dp, input logic [7:0] ds,
                         input logic [7:0] dg, input logic [7:0] da);
        @(posedge clk_i);
        pins_cmd  <= dp;
        speed_cmd <= ds;
        gear_cmd  <= dg;
        amps_cmd  <= da;
        repeat (8) @(posedge clk_i);
    endtask : drive

    function automatic logic cond_ok(input logic [4:0] c,
        input logic [5:0] cp, input logic [7:0] cs, input logic [7:0] cg);
        case (c)
            5'h00: return 1'b1;
            5'h01: return cp[1];
            5'h02: return !cp[1];
            5'h03: return cp[2];
            5'h04: return !cp[2];
            5'h05: return cp[3];
            5'h06: return !cp[3];
            5'h07: return cp[4];
            5'h08: return !cp[4];
            5'h09: return cs > spd_thr;
            5'h0A: return cs < spd_thr;
            5'h0B: return cs == 8'h00;
            5'h0C: return cs != 8'h00;
            5'h0D: return cp[5] && cg > gear_thr;
            5'h0E: return cp[5] && cg < gear_thr;
            5'h0F: return cp[5] && cg == 8'h7D;
            5'h10: return cp[5] && cg != 8'h7D;
            default: return 1'b0;
        endcase
    endfunction : cond_ok

    //==========================================================
    // Scenarios
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_CTRL, 32'h0000_01FF, 32'h0000_000A);
        rd(A_SPEED, 32'h0000_007F, 32'h0000_001E);
        rd(A_GEAR, 32'h0000_00FF, 32'h0000_0000);
        rd(A_FUSE, 32'h0000_00FF, 32'h0000_00C8);
        status(1'b0, 1'b0);
        wr(5'h14, 32'h0000_00FF);
        rd(5'h14, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(A_SPEED, 32'h0000_0065);
        rd(A_SPEED, 32'h0000_007F, 32'h0000_0064);
        // Codes 0 to 17 (every legal code and one illegal), thresholds random, boundary speeds and gears
        for (int c = 0; c <= 17; c++) begin
            spd_thr  = 8'($unsigned($random(seed)) % 101);
            gear_thr = 8'($random(seed));
            wr(A_SPEED, {24'h0, spd_thr});
            wr(A_GEAR, {24'h0, gear_thr});
            wr(A_CTRL, {27'h0, 5'(c)});
            for (int k = 0; k < 6; k++) begin
                p = {6'($random(seed))} | 6'h01;
                p[0] = (k != 5);
                s = (k < 3) ? spd_thr + 8'(k) - 8'h01 :
                    (k == 3) ? 8'h00 : 8'($random(seed));
                g = (k < 3) ? gear_thr + 8'(k) - 8'h01 :
                    (k == 3) ? 8'h7D : 8'($random(seed));
                drive(p, s, g, 8'h00);
                status(p[0] && cond_ok(5'(c), p, s, g), 1'b0);
            end
        end
        // Latch-off: recovery alone must not restore the output
        wr(A_CTRL, 32'h0000_0101);
        drive(6'h03, 8'h00, 8'h00, 8'h00);
        status(1'b1, 1'b0);
        drive(6'h01, 8'h00, 8'h00, 8'h00);
        status(1'b0, 1'b0);
        rd(iao_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
        drive(6'h03, 8'h00, 8'h00, 8'h00);
        status(1'b0, 1'b0);
        drive(6'h02, 8'h00, 8'h00, 8'h00);
        drive(6'h03, 8'h00, 8'h00, 8'h00);
        status(1'b1, 1'b0);
        // Fuse level at 5.0 A, then trip and switch recycle
        wr(A_CTRL, 32'h0000_0000);
        wr(A_FUSE, 32'h0000_0032);
        drive(6'h01, 8'h00, 8'h00, 8'h31);
        status(1'b1, 1'b0);
        drive(6'h01, 8'h00, 8'h00, 8'h32);
        status(1'b0, 1'b1);
        drive(6'h01, 8'h00, 8'h00, 8'h00);
        status(1'b0, 1'b1);
        drive(6'h00, 8'h00, 8'h00, 8'h00);
        drive(6'h01, 8'h00, 8'h00, 8'h00);
        status(1'b1, 1'b0);
        wr(A_FUSE, 32'h0000_0000);
        rd(A_FUSE, 32'h0000_00FF, 32'h0000_000A);
        wr(A_FUSE, 32'h0000_00FF);
        rd(A_FUSE, 32'h0000_00FF, 32'h0000_00C8);
        repeat (4) @(posedge clk_i);
        end_of_test();
    end
endmodule : iao_top_bench
